// ==== include/pisr_pkg.sv ====
package pisr_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_CORES = 2;
  localparam int LLC_WAYS = 16;
  localparam int WAY_W = 5;

  // ==========================================================
  // core idle levels, ordered shallow to deep
  typedef logic [2:0] pisr_lvl_t;
  localparam pisr_lvl_t LVL_C0 = 3'h0;
  localparam pisr_lvl_t LVL_C1 = 3'h1;
  localparam pisr_lvl_t LVL_C3 = 3'h2;
  localparam pisr_lvl_t LVL_C6 = 3'h3;
  localparam pisr_lvl_t LVL_C7 = 3'h4;
  localparam pisr_lvl_t LVL_C8 = 3'h5;
  localparam pisr_lvl_t LVL_C9 = 3'h6;
  localparam pisr_lvl_t LVL_C10 = 3'h7;

  // ==========================================================
  // package states, declared shallow to deep so that > means deeper
  typedef enum logic [3:0] {
    PK_C0, PK_C1, PK_C1E, PK_C2, PK_C3, PK_C6, PK_C7, PK_C8, PK_C9, PK_C10
  } pisr_pkg_state_e;

  // ==========================================================
  // carriers
  typedef struct packed {
    pisr_lvl_t lvl;
    logic c1e_hint;
    logic flush_all_hint;
  } pisr_core_req_s;

  typedef struct packed {
    logic grant_lp;
    logic allow_c6;
    logic grant_c7;
    logic hold_shallow;
    logic latency_block;
  } pisr_plat_s;

  typedef struct packed {
    logic c1e_en;
    logic c1e_autopromo;
    logic limit_c1;
  } pisr_cfg_s;

  typedef struct packed {
    logic clk_min;
    logic v_low;
    logic sa_off;
    logic rails_off;
    logic vcc_zero;
    logic vr_deep;
  } pisr_pwr_s;

  // ==========================================================
  // reset values and timing
  localparam logic [WAY_W-1:0] WAYS_RST = 5'h10;
  localparam logic [WAY_W-1:0] FLUSH_STEP = 5'h04;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int FREQ_SETTLE_NS = 32;
  localparam int FREQ_SETTLE_CYC = (FREQ_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EXPAND_GAP_NS = 64;
  localparam int EXPAND_GAP_CYC = (EXPAND_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] SETTLE_LAST = 4'(FREQ_SETTLE_CYC - 1);
  localparam logic [3:0] EXPAND_LAST = 4'(EXPAND_GAP_CYC - 1);

endpackage

// ==== verilog/pisr_llc_sizer.sv ====
`timescale 1ns/1ps
module pisr_llc_sizer (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic en_i,
  input wire logic flush_req_i,
  input wire logic flush_all_i,
  input wire logic expand_i,
  output logic [pisr_pkg::WAY_W-1:0] ways_o,
  output logic flush_o
);
  import pisr_pkg::*;

  // ==========================================================
  // way count
  logic [WAY_W-1:0] ways_q, ways_d;
  logic [3:0] gap_q, gap_d;
  logic flush_q, flush_d;
  wire can_flush = flush_req_i && (ways_q != 5'h00);
  wire big_step = flush_all_i || (ways_q < FLUSH_STEP);
  wire can_grow = expand_i && !flush_req_i && (ways_q < WAYS_RST);
  wire gap_done = (gap_q == EXPAND_LAST);

  always_comb begin
    ways_d = ways_q;
    gap_d = 4'h0;
    flush_d = 1'b0;
    if (can_flush) begin
      // a few ways per cycle, or everything at once
      ways_d = big_step ? 5'h00 : ways_q - FLUSH_STEP;
      flush_d = 1'b1;
    end else if (can_grow) begin
      // regrow one way at a time so the refill traffic stays spread out
      gap_d = gap_done ? 4'h0 : gap_q + 4'h1;
      if (gap_done) begin
        ways_d = ways_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ways_q <= WAYS_RST;
      gap_q <= 4'h0;
      flush_q <= 1'b0;
    end else if (en_i) begin
      ways_q <= ways_d;
      gap_q <= gap_d;
      flush_q <= flush_d;
    end
  end

  assign ways_o = ways_q;
  assign flush_o = flush_q;

endmodule

// ==== verilog/pisr_resolver.sv ====
`timescale 1ns/1ps
// Function
// - package request is lowest core level
// - cores may idle deeper than package
// - idle states move directly, skipping C0
// - unmasked core break wakes core, package C0
// - masked core break returns to prior state
// - memory wake returns to prior state
// - platform hold keeps shallower state during service
// - two cores resolve to the shallower level
// - enhanced halt enabled gives C1E when shallowest core is C1
// - package C0 on active core or no grant
// - C1E lowers clock first, then voltage
// - package C1 when all cores C1 or deeper
// - C1E by hint, limit, or autopromotion
// - no system notice entering C1 or C1E
// - C2 internal only, on latency constraints
// - memory request in deep idle gives C2
// - C3 needs grant, cache stays valid
// - C6 when allowed but C7 not granted
// - no flush while any core requests C6
// - C7 needs all cores C7, agent off
// - C8 to C10 add cumulative power-off steps
// - deep request flushes cache, C0 regrows it
// - auto-demotion off until firmware enables it
module pisr_resolver (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic en_i,
  input wire pisr_pkg::pisr_core_req_s [pisr_pkg::NUM_CORES-1:0] core_req_i,
  input wire logic gfx_deep_i,
  input wire pisr_pkg::pisr_plat_s plat_i,
  input wire pisr_pkg::pisr_cfg_s cfg_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_autodemote_i,
  input wire logic [pisr_pkg::NUM_CORES-1:0] brk_core_i,
  input wire logic [pisr_pkg::NUM_CORES-1:0] brk_mask_i,
  input wire logic mem_req_i,
  input wire logic mem_busy_i,
  output pisr_pkg::pisr_pkg_state_e pkg_state_o,
  output logic [pisr_pkg::NUM_CORES-1:0] core_wake_o,
  output logic [pisr_pkg::NUM_CORES-1:0] brk_fwd_o,
  output pisr_pkg::pisr_pwr_s pwr_o,
  output logic sys_notify_o,
  output logic llc_flush_o,
  output logic [pisr_pkg::WAY_W-1:0] llc_ways_o,
  output logic autodemote_en_o
);
  import pisr_pkg::*;

  // ==========================================================
  // per-core reduction
  pisr_lvl_t min_chain [NUM_CORES:0];
  logic [NUM_CORES:0] hint_chain;
  logic [NUM_CORES:0] c6_chain;
  logic [NUM_CORES:0] fall_chain;
  assign min_chain[0] = LVL_C10;
  assign hint_chain[0] = 1'b1;
  assign c6_chain[0] = 1'b0;
  assign fall_chain[0] = 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CORES; gi++) begin : g_core
      // shallowest level wins
      assign min_chain[gi+1] = (core_req_i[gi].lvl < min_chain[gi]) ?
                               core_req_i[gi].lvl : min_chain[gi];
      assign hint_chain[gi+1] = hint_chain[gi] && core_req_i[gi].c1e_hint;
      assign c6_chain[gi+1] = c6_chain[gi] || (core_req_i[gi].lvl == LVL_C6);
      assign fall_chain[gi+1] = fall_chain[gi] || core_req_i[gi].flush_all_hint;
    end
  endgenerate

  wire pisr_lvl_t min_lvl = min_chain[NUM_CORES];
  wire all_c1e_hint = hint_chain[NUM_CORES];
  wire any_c6 = c6_chain[NUM_CORES];
  wire flush_all_hint = fall_chain[NUM_CORES];

  // ==========================================================
  // break events
  wire [NUM_CORES-1:0] brk_live = brk_core_i & ~brk_mask_i;
  wire brk_unmasked = |brk_live;
  wire brk_masked = |(brk_core_i & brk_mask_i);
  wire deep_idle = (min_lvl >= LVL_C3) && gfx_deep_i;

  // ==========================================================
  // registers
  pisr_pkg_state_e state_q, state_d;
  pisr_pkg_state_e prior_q;
  logic [NUM_CORES-1:0] hold_c0_q;
  logic svc_q, svc_d;
  logic [NUM_CORES-1:0] wake_q, fwd_q;
  logic clk_min_q, v_low_q;
  logic [3:0] settle_q;
  logic notify_q;
  logic demote_q;
  pisr_pwr_s pwr_d;

  // ==========================================================
  // memory and snoop service
  wire mem_wake = mem_req_i && deep_idle && (state_q >= PK_C2);
  wire svc_end = !mem_busy_i && !plat_i.hold_shallow;
  always_comb begin
    svc_d = svc_q;
    if (mem_wake) begin
      svc_d = 1'b1;
    end else if (svc_end) begin
      svc_d = 1'b0;
    end
  end

  // ==========================================================
  // target resolution
  // autopromotion alone is enough, firmware need not set both bits
  wire c1e_sel = all_c1e_hint ||
                 cfg_i.c1e_autopromo ||
                 cfg_i.c1e_en;
  wire core_pinned = |(hold_c0_q & ~brk_core_i);

  pisr_pkg_state_e idle_tgt;
  always_comb begin
    // cores keep their own levels; only the package is capped here
    idle_tgt = PK_C0;
    if (min_lvl == LVL_C1) begin
      idle_tgt = c1e_sel ? PK_C1E : PK_C1;
    end else if (cfg_i.limit_c1) begin
      idle_tgt = PK_C1E;
    end else if (!gfx_deep_i) begin
      idle_tgt = PK_C1;
    end else if (svc_q || plat_i.latency_block) begin
      idle_tgt = PK_C2;
    end else if (min_lvl == LVL_C3 || !plat_i.allow_c6) begin
      idle_tgt = PK_C3;
    end else if (min_lvl == LVL_C6 || !plat_i.grant_c7) begin
      idle_tgt = PK_C6;
    end else begin
      case (min_lvl)
        LVL_C7: idle_tgt = PK_C7;
        LVL_C8: idle_tgt = PK_C8;
        LVL_C9: idle_tgt = PK_C9;
        LVL_C10: idle_tgt = PK_C10;
        default: idle_tgt = PK_C6;
      endcase
    end
  end

  always_comb begin
    state_d = idle_tgt;
    if (brk_unmasked || core_pinned) begin
      state_d = PK_C0;
    end else if (min_lvl == LVL_C0 || !plat_i.grant_lp) begin
      state_d = PK_C0;
    end else if (brk_masked && state_q != PK_C0) begin
      state_d = prior_q;
    end
  end

  // ==========================================================
  // package state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= PK_C0;
      prior_q <= PK_C0;
      svc_q <= 1'b0;
    end else if (en_i) begin
      state_q <= state_d;
      svc_q <= svc_d;
      if (state_q != PK_C0) begin
        prior_q <= state_q;
      end
    end
  end

  // ==========================================================
  // core wake and forwarding
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wake_q <= '0;
      fwd_q <= '0;
      hold_c0_q <= '0;
    end else if (en_i) begin
      wake_q <= brk_core_i;
      fwd_q <= brk_core_i;
      for (int i = 0; i < NUM_CORES; i++) begin
        // pin the package at C0 until the woken core reports active
        if (brk_live[i]) begin
          hold_c0_q[i] <= 1'b1;
        end else if (core_req_i[i].lvl == LVL_C0) begin
          hold_c0_q[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // enhanced halt clock then voltage
  wire in_c1e = (state_q == PK_C1E);
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      clk_min_q <= 1'b0;
      v_low_q <= 1'b0;
      settle_q <= 4'h0;
    end else if (en_i) begin
      clk_min_q <= in_c1e;
      if (!in_c1e || !clk_min_q) begin
        settle_q <= 4'h0;
        v_low_q <= 1'b0;
      end else if (settle_q == SETTLE_LAST) begin
        v_low_q <= 1'b1;
      end else begin
        settle_q <= settle_q + 4'h1;
      end
    end
  end

  // ==========================================================
  // deeper power actions accumulate
  always_comb begin
    pwr_d = '0;
    pwr_d.sa_off = (state_q >= PK_C7);
    pwr_d.rails_off = (state_q >= PK_C8);
    pwr_d.vcc_zero = (state_q >= PK_C9);
    pwr_d.vr_deep = (state_q >= PK_C10);
  end

  pisr_pwr_s pwr_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pwr_q <= '0;
    end else if (en_i) begin
      pwr_q <= pwr_d;
    end
  end

  // ==========================================================
  // system notice, only for states that reach the platform
  wire deep_entry = (state_d >= PK_C3) && (state_d != state_q);
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      notify_q <= 1'b0;
    end else if (en_i) begin
      notify_q <= deep_entry;
    end
  end

  // ==========================================================
  // auto-demotion enable, off from reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      demote_q <= 1'b0;
    end else if (en_i && cfg_wr_i) begin
      demote_q <= cfg_autodemote_i;
    end
  end

  // ==========================================================
  // shared cache sizing
  // C3 never flushes, so the cache keeps its contents there
  wire flush_req = (min_lvl >= LVL_C7) && (state_q >= PK_C6) && !any_c6;
  wire expand = (state_q == PK_C0);

  pisr_llc_sizer u_llc (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .en_i(en_i),
    .flush_req_i(flush_req),
    .flush_all_i(flush_all_hint),
    .expand_i(expand),
    .ways_o(llc_ways_o),
    .flush_o(llc_flush_o)
  );

  // ==========================================================
  // outputs
  assign pkg_state_o = state_q;
  assign core_wake_o = wake_q;
  assign brk_fwd_o = fwd_q;
  assign sys_notify_o = notify_q;
  assign autodemote_en_o = demote_q;
  always_comb begin
    pwr_o = pwr_q;
    pwr_o.clk_min = clk_min_q;
    pwr_o.v_low = v_low_q;
  end

  // ==========================================================
  // checks
  wire quiet = en_i && !brk_unmasked && !core_pinned && !brk_masked;
  wire granted = quiet && plat_i.grant_lp && min_lvl != LVL_C0;

  sequence s_unmasked_brk;
    en_i && brk_unmasked;
  endsequence

  sequence s_woken;
    state_q == PK_C0 && core_wake_o != '0;
  endsequence

  sequence s_clock_dropped;
    en_i && in_c1e && !clk_min_q ##1 clk_min_q;
  endsequence

  AST_ACTIVE_C0: assert property (@(posedge clk_i) disable iff (srst_i)
    en_i && min_lvl == LVL_C0 |=> state_q == PK_C0)
    else $error("active core did not keep package in C0");

  AST_NO_GRANT: assert property (@(posedge clk_i) disable iff (srst_i)
    en_i && !plat_i.grant_lp |=> state_q == PK_C0)
    else $error("package left C0 without grant");

  AST_PLAIN_C1: assert property (@(posedge clk_i) disable iff (srst_i)
    granted && min_lvl == LVL_C1 && !c1e_sel |=> state_q == PK_C1)
    else $error("package C1 not entered");

  AST_ENH_C1: assert property (@(posedge clk_i) disable iff (srst_i)
    granted && min_lvl == LVL_C1 && cfg_i.c1e_en |=> state_q == PK_C1E)
    else $error("enhanced C1 not entered");

  AST_LIMIT_C1: assert property (@(posedge clk_i) disable iff (srst_i)
    granted && min_lvl >= LVL_C3 && cfg_i.limit_c1 |=> state_q == PK_C1E)
    else $error("limit did not cap package at enhanced C1");

  AST_MEM_C2: assert property (@(posedge clk_i) disable iff (srst_i)
    granted && svc_q && gfx_deep_i && min_lvl >= LVL_C3 && !cfg_i.limit_c1
    |=> state_q == PK_C2)
    else $error("memory service did not hold C2");

  AST_BRK_WAKE: assert property (@(posedge clk_i) disable iff (srst_i)
    s_unmasked_brk |=> s_woken)
    else $error("unmasked break did not wake to C0");

  AST_C1E_ORDER: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(v_low_q) |-> clk_min_q && $past(clk_min_q, 4))
    else $error("voltage dropped before clock settled");

  AST_C1E_SETTLE: assert property (@(posedge clk_i) disable iff (srst_i)
    s_clock_dropped ##0 (en_i && in_c1e) [*4] |=> v_low_q)
    else $error("voltage not lowered after settle time");

  AST_NO_NOTIFY: assert property (@(posedge clk_i) disable iff (srst_i)
    sys_notify_o |-> state_q != PK_C1 && state_q != PK_C1E && state_q != PK_C0)
    else $error("notice raised for a shallow state");

  AST_C3_KEEP: assert property (@(posedge clk_i) disable iff (srst_i)
    en_i && state_q == PK_C3 |=> !llc_flush_o)
    else $error("cache flushed in package C3");

  AST_C6_KEEP: assert property (@(posedge clk_i) disable iff (srst_i)
    en_i && any_c6 |=> !llc_flush_o)
    else $error("cache flushed while a core requests C6");

  AST_RAILS: assert property (@(posedge clk_i) disable iff (srst_i)
    en_i && state_q >= PK_C8 |=> pwr_o.rails_off && pwr_o.sa_off)
    else $error("rails not off in C8 or deeper");

  AST_DEMOTE_RST: assert property (@(posedge clk_i)
    srst_i |=> !autodemote_en_o)
    else $error("auto-demotion enabled out of reset");

endmodule

// ==== test/pisr_plat_model.sv ====
`timescale 1ns/1ps
module pisr_plat_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [1:0] lim_i,
  input wire logic hold_i,
  input wire logic lat_i,
  input wire logic slow_i,
  output pisr_pkg::pisr_plat_s plat_o
);
  import pisr_pkg::*;
  // ==========================================================
  // grant decode
  pisr_plat_s want;
  pisr_plat_s pipe_q [4];
  // deeper grants imply the shallower ones, never the reverse
  assign want.grant_lp = (lim_i != 2'h0);
  assign want.allow_c6 = (lim_i >= 2'h2);
  assign want.grant_c7 = (lim_i == 2'h3);
  assign want.hold_shallow = hold_i;
  assign want.latency_block = lat_i;
  // ==========================================================
  // answer delay: a slow controller lags three cycles more
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pipe_q <= '{default: '0};
    end else begin
      pipe_q <= '{want, pipe_q[0], pipe_q[1], pipe_q[2]};
    end
  end
  assign plat_o = slow_i ? pipe_q[3] : pipe_q[0];
endmodule

// ==== test/tb_pisr_resolver.sv ====
`timescale 1ns/1ps
module tb_pisr_resolver;
  import pisr_pkg::*;
  typedef struct packed {
    pisr_lvl_t l0;
    pisr_lvl_t l1;
    logic gfx;
    logic [1:0] lim;
    logic lat;
    logic hint;
    pisr_cfg_s cfg;
    logic slow;
    pisr_pkg_state_e exp;
  } pisr_tb_row_s;
  // ==========================================================
  // ordinary cases: levels, graphics, grant, latency, hint, cfg, slow
  localparam pisr_tb_row_s ROWS [17] = '{
    '{LVL_C0, LVL_C6, 1'b1, 2'h3, 1'b0, 1'b0, 3'h0, 1'b0, PK_C0},
    '{LVL_C1, LVL_C3, 1'b1, 2'h3, 1'b0, 1'b0, 3'h0, 1'b0, PK_C1},
    '{LVL_C1, LVL_C7, 1'b1, 2'h3, 1'b0, 1'b0, 3'h4, 1'b0, PK_C1E},
    '{LVL_C1, LVL_C1, 1'b1, 2'h3, 1'b0, 1'b1, 3'h0, 1'b0, PK_C1E},
    '{LVL_C3, LVL_C8, 1'b1, 2'h3, 1'b0, 1'b0, 3'h0, 1'b1, PK_C3},
    '{LVL_C6, LVL_C7, 1'b1, 2'h3, 1'b0, 1'b0, 3'h0, 1'b0, PK_C6},
    '{LVL_C7, LVL_C10, 1'b1, 2'h3, 1'b0, 1'b0, 3'h0, 1'b0, PK_C7},
    '{LVL_C9, LVL_C8, 1'b1, 2'h3, 1'b0, 1'b0, 3'h0, 1'b0, PK_C8},
    '{LVL_C9, LVL_C10, 1'b1, 2'h3, 1'b0, 1'b0, 3'h0, 1'b1, PK_C9},
    '{LVL_C10, LVL_C10, 1'b1, 2'h3, 1'b0, 1'b0, 3'h0, 1'b0, PK_C10},
    '{LVL_C7, LVL_C7, 1'b1, 2'h2, 1'b0, 1'b0, 3'h0, 1'b0, PK_C6},
    '{LVL_C7, LVL_C7, 1'b1, 2'h1, 1'b0, 1'b0, 3'h0, 1'b0, PK_C3},
    '{LVL_C6, LVL_C6, 1'b1, 2'h3, 1'b1, 1'b0, 3'h0, 1'b0, PK_C2},
    '{LVL_C7, LVL_C7, 1'b1, 2'h3, 1'b0, 1'b0, 3'h1, 1'b0, PK_C1E},
    '{LVL_C6, LVL_C6, 1'b1, 2'h0, 1'b0, 1'b0, 3'h0, 1'b1, PK_C0},
    '{LVL_C3, LVL_C3, 1'b0, 2'h3, 1'b0, 1'b0, 3'h0, 1'b0, PK_C1},
    '{LVL_C1, LVL_C1, 1'b1, 2'h3, 1'b0, 1'b0, 3'h2, 1'b0, PK_C1E}
  };
  logic clk, srst, en, gfx, cfg_wr, cfg_ad, mem_req, mem_busy, hold, lat, slow;
  logic notify, flush, ad_en;
  logic [1:0] lim, brk, bmask, wake, fwd;
  logic [WAY_W-1:0] ways;
  pisr_core_req_s [NUM_CORES-1:0] req;
  pisr_plat_s plat;
  pisr_cfg_s cfg;
  pisr_pkg_state_e st;
  pisr_pwr_s pwr;
  int n_fail, n_compared, n_flush, n_note, bad;

  pisr_plat_model i_plat (.clk_i(clk), .srst_i(srst), .lim_i(lim), .hold_i(hold),
    .lat_i(lat), .slow_i(slow), .plat_o(plat));
  pisr_resolver i_dut (.clk_i(clk), .srst_i(srst), .en_i(en), .core_req_i(req),
    .gfx_deep_i(gfx), .plat_i(plat), .cfg_i(cfg), .cfg_wr_i(cfg_wr),
    .cfg_autodemote_i(cfg_ad), .brk_core_i(brk), .brk_mask_i(bmask),
    .mem_req_i(mem_req), .mem_busy_i(mem_busy), .pkg_state_o(st), .core_wake_o(wake),
    .brk_fwd_o(fwd), .pwr_o(pwr), .sys_notify_o(notify), .llc_flush_o(flush),
    .llc_ways_o(ways), .autodemote_en_o(ad_en));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // pulses are counted at the edge so none is missed between checks
  always @(posedge clk) begin
    n_flush += int'(flush);
    n_note += int'(notify);
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic go(input pisr_lvl_t a, input pisr_lvl_t b, input int n);
    req[0].lvl = a;
    req[1].lvl = b;
    cyc(n);
  endtask
  task automatic note(input string s);
    $display("test %s finished", s);
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #(8 * 6000);
    n_fail++;
    print_verdict();
  end

  // ==========================================================
  // sequence
  initial begin
    {srst, en, gfx, cfg_wr, cfg_ad, mem_req, mem_busy, hold, lat, slow} = 10'h381;
    {req, cfg, brk, bmask} = '0;
    lim = 2'h3;
    cyc(20);
    chk(16'(st), 16'(PK_C0));
    chk(16'(ways), 16'(WAYS_RST));
    chk(16'(pwr), 16'h0);
    chk(16'(ad_en), 16'h0);
    srst = 1'b0;
    note("reset");
    cfg_wr = 1'b1;
    cfg_ad = 1'b1;
    cyc(1);
    cfg_wr = 1'b0;
    chk(16'(ad_en), 16'h1);
    foreach (ROWS[i]) begin
      {gfx, lim, lat} = {ROWS[i].gfx, ROWS[i].lim, ROWS[i].lat};
      {slow, cfg} = {ROWS[i].slow, ROWS[i].cfg};
      req[0].c1e_hint = ROWS[i].hint;
      req[1].c1e_hint = ROWS[i].hint;
      bad = 0;
      // idle-to-idle moves must never pass through the active state
      for (int k = 0; k < 8; k++) begin
        go(ROWS[i].l0, ROWS[i].l1, 1);
        if (i > 0 && ROWS[i-1].exp != PK_C0 && ROWS[i].exp != PK_C0 && st === PK_C0) bad++;
      end
      chk(16'(st), 16'(ROWS[i].exp));
      chk(16'(bad), 16'h0);
    end
    note("table");
    {gfx, lim, lat, slow, cfg, req} = {1'b1, 2'h3, 5'h0, 10'h0};
    go(LVL_C7, LVL_C7, 8);
    brk = 2'h1;
    cyc(1);
    brk = 2'h0;
    chk(16'({wake, fwd}), 16'h5);
    chk(16'(st), 16'(PK_C0));
    cyc(3);
    chk(16'(st), 16'(PK_C0));
    go(LVL_C0, LVL_C7, 2);
    go(LVL_C7, LVL_C7, 8);
    brk = 2'h2;
    bmask = 2'h2;
    cyc(1);
    brk = 2'h0;
    chk(16'({wake, fwd}), 16'ha);
    chk(16'(st), 16'(PK_C7));
    cyc(4);
    chk(16'(st), 16'(PK_C7));
    bmask = 2'h0;
    note("break");
    {mem_req, mem_busy} = 2'h3;
    cyc(1);
    mem_req = 1'b0;
    cyc(2);
    chk(16'(st), 16'(PK_C2));
    mem_busy = 1'b0;
    cyc(4);
    chk(16'(st), 16'(PK_C7));
    {mem_req, mem_busy, hold} = 3'h7;
    cyc(1);
    mem_req = 1'b0;
    cyc(3);
    mem_busy = 1'b0;
    cyc(6);
    chk(16'(st), 16'(PK_C2));
    hold = 1'b0;
    cyc(6);
    chk(16'(st), 16'(PK_C7));
    note("memory");
    go(LVL_C0, LVL_C0, 140);
    chk(16'(ways), 16'(WAYS_RST));
    go(LVL_C6, LVL_C7, 20);
    chk(16'(ways), 16'(WAYS_RST));
    n_flush = 0;
    go(LVL_C7, LVL_C7, 12);
    chk(16'(ways), 16'h0);
    chk(16'(n_flush), 16'h4);
    go(LVL_C0, LVL_C0, 20);
    chk(16'(ways != 5'h0 && ways < WAYS_RST), 16'h1);
    go(LVL_C0, LVL_C0, 130);
    req[0].flush_all_hint = 1'b1;
    req[1].flush_all_hint = 1'b1;
    n_flush = 0;
    go(LVL_C7, LVL_C7, 6);
    chk(16'(ways), 16'h0);
    chk(16'(n_flush), 16'h1);
    req[0].flush_all_hint = 1'b0;
    req[1].flush_all_hint = 1'b0;
    note("cache");
    go(LVL_C0, LVL_C0, 4);
    cfg.c1e_en = 1'b1;
    n_note = 0;
    go(LVL_C1, LVL_C1, 2);
    chk(16'(st), 16'(PK_C1E));
    chk(16'({pwr.clk_min, pwr.v_low}), 16'h2);
    cyc(3);
    chk(16'(pwr.v_low), 16'h0);
    cyc(1);
    chk(16'(pwr.v_low), 16'h1);
    chk(16'(n_note), 16'h0);
    cfg.c1e_en = 1'b0;
    cyc(4);
    chk(16'(st), 16'(PK_C1));
    chk(16'(pwr), 16'h0);
    note("enhanced halt");
    en = 1'b0;
    go(LVL_C7, LVL_C7, 4);
    chk(16'(st), 16'(PK_C1));
    n_note = 0;
    en = 1'b1;
    cyc(8);
    chk(16'(n_note), 16'h1);
    srst = 1'b1;
    cyc(2);
    chk(16'(st), 16'(PK_C0));
    chk(16'(ad_en), 16'h0);
    srst = 1'b0;
    note("freeze and reset");
    print_verdict();
  end
endmodule
